// ---- hdl/rss_pkg.sv ----
package rss_pkg;

	// ********************
	// timing
	// ********************
	localparam int CLK_NS = 4;
	localparam int PIN_MIN_NS = 100;
	localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_CYC = 4096;
	localparam int PIN_CYC = 32;
	localparam int HOLD_CYC = 32;
	localparam int FIN_CYC = 3;
	localparam int WAKE_SHORT_CYC = 32;
	localparam int WAKE_LONG_CYC = 4096;
	localparam logic [7:0] PIN_MIN_CNT = 8'(PIN_MIN_CYC);
	localparam logic [11:0] LONG_LAST = 12'(LONG_CYC - 1);
	localparam logic [11:0] PRESC_LAST = 12'hFFF;
	localparam logic [5:0] PIN_LAST = 6'(PIN_CYC - 1);
	localparam logic [5:0] HOLD_LAST = 6'(HOLD_CYC - 1);
	localparam logic [5:0] FIN_LAST = 6'(FIN_CYC - 1);
	localparam logic [11:0] WAKE_SHORT_LAST = 12'(WAKE_SHORT_CYC - 1);
	localparam logic [11:0] WAKE_LONG_LAST = 12'(WAKE_LONG_CYC - 1);
	localparam logic [5:0] WD_LAST = 6'h3F;

	// ********************
	// register map
	// ********************
	localparam logic [7:0] A_CAUSE = 8'h00;
	localparam logic [7:0] A_OPT1 = 8'h04;
	localparam logic [7:0] A_OPT2 = 8'h08;
	localparam logic [7:0] A_BRK = 8'h0C;
	localparam logic [7:0] A_WDSVC = 8'h10;
	localparam int C_PWR = 0;
	localparam int C_PIN = 1;
	localparam int C_WD = 2;
	localparam int C_BOP = 3;
	localparam int C_BF = 4;
	localparam int C_BO = 5;
	localparam int OPT1_SHORT = 0;
	localparam int OPT1_STOPEN = 1;
	localparam int SVC_LO = 4;
	localparam logic [5:0] CAUSE_RST = 6'h01;
	localparam logic [1:0] OPT1_RST = 2'h0;
	localparam logic OPT2_RST = 1'b0;
	localparam logic BRK_RST = 1'b0;

	// ********************
	// sequencer states
	// ********************
	typedef enum logic [2:0] {
		ST_LONG = 3'h0,
		ST_PIN = 3'h1,
		ST_HOLD = 3'h3,
		ST_FIN = 3'h2,
		ST_RUN = 3'h6,
		ST_STOP = 3'h7,
		ST_WAKE = 3'h5,
		ST_EXT = 3'h4
	} rss_state_e;

endpackage

// ---- hdl/rss_sequencer.sv ----
// What this block does
// - any reset source asserts chip reset, restoring registers, then releases to vector fetch.
// - internal resets clear the prescaler; external pin reset leaves it running.
// - each source sets its own flag in the reset cause register.
// - pin held low halts processing; pin flag needs minimum low time.
// - pin is plain input until reset pin function enable is set.
// - power-up and brownout first count 4096 cycles; pin is low there only for brownout with reset pin function set.
// - internal resets drive pin low 32 cycles, then hold reset 35 more.
// - recovery is 4163 cycles for power-up/brownout, 67 for other internal resets.
// - power-up enables oscillator, gates clocks for all 4163 reset cycles, sets flag, releases after them.
// - watchdog overflow causes internal reset and sets its flag.
// - service write clears watchdog and prescaler stages 12 to 5.
// - prescaler clocks the watchdog every 4096 cycles; after a service write the next clock comes 4080 to 4095 cycles later.
// - watchdog stops during monitor break when break watchdog disable is set.
// - illegal opcode sets its flag and resets.
// - stop with stop enable clear counts as illegal opcode.
// - opcode fetch from unmapped address resets; data read does not.
// - brownout holds pin low until 4128 cycles after recovery, then releases.
// - prescaler has 12 stages plus a 13th that wraps and clocks watchdog.
// - prescaler advances once per quad rate clock period.
// - stop instruction clears the prescaler.
// - stop wake delay is 32 cycles with short wake, else 4096.
// - prescaler runs freely after every reset completes.
// - bus clock runs at one quarter of the quad rate clock.
module rss_sequencer (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	// reset sources
	input wire logic power_up_reset_req_i,
	input wire logic brownout_detect_i,
	input wire logic bad_opcode_i,
	input wire logic stop_exec_i,
	input wire logic opcode_fetch_i,
	input wire logic addr_unmapped_i,
	// break and stop wake
	input wire logic break_active_i,
	input wire logic monitor_mode_i,
	input wire logic wake_i,
	// reset pin, open drain
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_o,
	output logic pin_gpio_o,
	// chip control
	output logic chip_reset_o,
	output logic osc_en_o,
	output logic internal_bus_clocks_o,
	output logic bus_clk_en_o
);

	typedef struct packed {
		rss_pkg::rss_state_e st;
		logic [11:0] presc;
		logic [5:0] step;
		logic [5:0] wd;
		logic [5:0] cause;
		logic [1:0] opt1;
		logic opt2;
		logic brk;
		logic [7:0] rdata;
		logic [2:0] pin_s;
		logic [2:0] bo_s;
		logic [2:0] pwr_s;
		logic pin_q;
		logic bo_q;
		logic pwr_q;
		logic [7:0] low_cnt;
		logic [1:0] ph;
		logic chip_rst;
		logic pin_drv;
		logic gpio;
	} rss_regs_s;

	rss_regs_s r;
	rss_regs_s n;
	logic presc_tick;
	logic wd_en;
	logic wd_ovf;
	logic long_src;
	logic ext_low;
	logic running;
	logic [5:0] src;
	logic quiet;
	logic svc_wr;

	// ********************
	// next state
	// ********************
	always_comb begin
		n = r;
		// three stage sync, change taken when stages two and three agree
		n.pin_s = {r.pin_s[1:0], reset_pin_i};
		n.bo_s = {r.bo_s[1:0], brownout_detect_i};
		n.pwr_s = {r.pwr_s[1:0], power_up_reset_req_i};
		if (r.pin_s[1] == r.pin_s[2]) begin
			n.pin_q = r.pin_s[2];
		end
		if (r.bo_s[1] == r.bo_s[2]) begin
			n.bo_q = r.bo_s[2];
		end
		if (r.pwr_s[1] == r.pwr_s[2]) begin
			n.pwr_q = r.pwr_s[2];
		end
		n.gpio = r.pin_q;
		n.ph = r.ph + 2'h1;
		n.rdata = 8'h00;

		// 13th stage: wrap of the 12 stages is the watchdog clock
		presc_tick = (r.presc == rss_pkg::PRESC_LAST);
		running = (r.st == rss_pkg::ST_RUN);
		wd_en = running && !(break_active_i && monitor_mode_i && r.brk);
		wd_ovf = wd_en && presc_tick && (r.wd == rss_pkg::WD_LAST);
		long_src = r.pwr_q || r.bo_q;
		ext_low = r.opt2 && !r.pin_q;

		// all simultaneous sources flag together
		src = 6'h00;
		src[rss_pkg::C_PWR] = r.pwr_q;
		src[rss_pkg::C_BO] = r.bo_q;
		src[rss_pkg::C_WD] = wd_ovf;
		src[rss_pkg::C_BOP] = running && (bad_opcode_i || (stop_exec_i && !r.opt1[rss_pkg::OPT1_STOPEN]));
		src[rss_pkg::C_BF] = running && opcode_fetch_i && addr_unmapped_i;

		// register reads, answered next cycle
		if (rd_i) begin
			case (addr_i)
				rss_pkg::A_CAUSE: n.rdata = {2'h0, r.cause};
				rss_pkg::A_OPT1: n.rdata = {6'h00, r.opt1};
				rss_pkg::A_OPT2: n.rdata = {7'h00, r.opt2};
				rss_pkg::A_BRK: n.rdata = {7'h00, r.brk};
				default: n.rdata = 8'h00;
			endcase
		end
		// register writes; reset entry below overrides, so a set wins a clear
		if (wr_i) begin
			case (addr_i)
				rss_pkg::A_CAUSE: n.cause = 6'h00;
				rss_pkg::A_OPT1: n.opt1 = wr_data_i[1:0];
				rss_pkg::A_OPT2: n.opt2 = wr_data_i[0];
				rss_pkg::A_BRK: n.brk = wr_data_i[0];
				rss_pkg::A_WDSVC: begin
					n.wd = 6'h00;
					n.presc[11:rss_pkg::SVC_LO] = 8'h00;
				end
				default: n.wd = r.wd;
			endcase
		end

		// sequencer
		case (r.st)
			rss_pkg::ST_RUN: begin
				n.presc = r.presc + 12'h001;
				if (wd_en && presc_tick) begin
					n.wd = r.wd + 6'h01;
				end
				if (wr_i && addr_i == rss_pkg::A_WDSVC) begin
					n.wd = 6'h00;
					n.presc[11:rss_pkg::SVC_LO] = 8'h00;
				end
				if (stop_exec_i && r.opt1[rss_pkg::OPT1_STOPEN]) begin
					n.st = rss_pkg::ST_STOP;
					n.presc = 12'h000;
				end
			end
			rss_pkg::ST_STOP: begin
				// oscillator off, counter parked at zero for the wake delay
				n.presc = 12'h000;
				if (wake_i) begin
					n.st = rss_pkg::ST_WAKE;
				end
			end
			rss_pkg::ST_WAKE: begin
				if (r.presc == (r.opt1[rss_pkg::OPT1_SHORT] ? rss_pkg::WAKE_SHORT_LAST : rss_pkg::WAKE_LONG_LAST)) begin
					n.st = rss_pkg::ST_RUN;
				end
				n.presc = r.presc + 12'h001;
			end
			rss_pkg::ST_LONG: begin
				// restarts while the source is still active, so timing runs from recovery
				if (long_src) begin
					n.presc = 12'h000;
				end else if (r.presc == rss_pkg::LONG_LAST) begin
					n.st = rss_pkg::ST_PIN;
					n.presc = r.presc + 12'h001;
				end else begin
					n.presc = r.presc + 12'h001;
				end
			end
			rss_pkg::ST_PIN: begin
				n.presc = r.presc + 12'h001;
				n.step = r.step + 6'h01;
				if (r.step == rss_pkg::PIN_LAST) begin
					n.st = rss_pkg::ST_HOLD;
					n.step = 6'h00;
				end
			end
			rss_pkg::ST_HOLD: begin
				n.presc = r.presc + 12'h001;
				n.step = r.step + 6'h01;
				if (r.step == rss_pkg::HOLD_LAST) begin
					n.st = rss_pkg::ST_FIN;
					n.step = 6'h00;
				end
			end
			rss_pkg::ST_FIN: begin
				n.presc = r.presc + 12'h001;
				n.step = r.step + 6'h01;
				if (r.step == rss_pkg::FIN_LAST) begin
					n.st = rss_pkg::ST_RUN;
					n.step = 6'h00;
				end
			end
			rss_pkg::ST_EXT: begin
				n.presc = r.presc + 12'h001;
				if (r.low_cnt != rss_pkg::PIN_MIN_CNT) begin
					n.low_cnt = r.low_cnt + 8'h01;
				end
				if (r.pin_q) begin
					n.st = rss_pkg::ST_HOLD;
					n.step = 6'h00;
					if (r.low_cnt == rss_pkg::PIN_MIN_CNT) begin
						n.cause = 6'h00;
						n.cause[rss_pkg::C_PIN] = 1'b1;
					end
				end
			end
			default: n.st = rss_pkg::ST_LONG;
		endcase

		// reset entry takes priority over everything above
		if (src != 6'h00) begin
			n.cause = src;
			n.presc = 12'h000;
			n.step = 6'h00;
			n.wd = 6'h00;
			n.opt1 = rss_pkg::OPT1_RST;
			n.brk = rss_pkg::BRK_RST;
			n.st = long_src ? rss_pkg::ST_LONG : rss_pkg::ST_PIN;
			if (src[rss_pkg::C_PWR]) begin
				n.opt2 = rss_pkg::OPT2_RST;
			end
		end else if (ext_low && (running || r.st == rss_pkg::ST_STOP || r.st == rss_pkg::ST_WAKE)) begin
			n.st = rss_pkg::ST_EXT;
			n.low_cnt = 8'h00;
			n.wd = 6'h00;
			n.opt1 = rss_pkg::OPT1_RST;
			n.brk = rss_pkg::BRK_RST;
		end

		n.chip_rst = !(n.st == rss_pkg::ST_RUN || n.st == rss_pkg::ST_STOP || n.st == rss_pkg::ST_WAKE);
		// pin only driven once software hands it the reset function
		n.pin_drv = n.opt2 && (n.st == rss_pkg::ST_LONG || n.st == rss_pkg::ST_PIN);
	end

	// ********************
	// state register
	// ********************
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			r <= '0;
			r.st <= rss_pkg::ST_LONG;
			r.cause <= rss_pkg::CAUSE_RST;
			r.opt1 <= rss_pkg::OPT1_RST;
			r.opt2 <= rss_pkg::OPT2_RST;
			r.brk <= rss_pkg::BRK_RST;
			r.pin_s <= 3'h7;
			r.pin_q <= 1'b1;
			r.gpio <= 1'b1;
			r.chip_rst <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ********************
	// outputs
	// ********************
	// open drain: only ever pulls low
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_o = r.pin_drv;
	assign pin_gpio_o = r.gpio;
	assign rd_data_o = r.rdata;
	assign chip_reset_o = r.chip_rst;
	assign osc_en_o = (r.st != rss_pkg::ST_STOP);
	assign internal_bus_clocks_o = (r.st == rss_pkg::ST_RUN);
	assign bus_clk_en_o = (r.st == rss_pkg::ST_RUN) && (r.ph == 2'h3);

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_pin_enter;
		$rose(r.st == rss_pkg::ST_PIN);
	endsequence

	sequence s_hold_enter;
		$rose(r.st == rss_pkg::ST_HOLD);
	endsequence

	a_pin_phase_len: assert property (s_pin_enter |-> ##31 r.st == rss_pkg::ST_PIN ##1 r.st == rss_pkg::ST_HOLD)
		else $error("pin phase length wrong");
	a_hold_to_release: assert property (s_hold_enter |-> ##32 r.st == rss_pkg::ST_FIN ##3 !chip_reset_o)
		else $error("reset release timing wrong");
	a_long_exit: assert property ((r.st == rss_pkg::ST_LONG && r.presc == rss_pkg::LONG_LAST && !long_src) |=> r.st == rss_pkg::ST_PIN)
		else $error("long phase exit wrong");
	a_ext_keeps_presc: assert property ((r.st == rss_pkg::ST_EXT && $past(r.st) == rss_pkg::ST_EXT) |-> r.presc == 12'($past(r.presc) + 12'h001))
		else $error("prescaler disturbed by pin reset");
	a_wdog_reset: assert property (wd_ovf |=> r.cause[rss_pkg::C_WD] && chip_reset_o && r.presc == 12'h000)
		else $error("watchdog overflow did not reset");
	a_bad_op_reset: assert property ((running && bad_opcode_i) |=> r.cause[rss_pkg::C_BOP] && chip_reset_o)
		else $error("illegal opcode did not reset");
	a_fetch_reset: assert property ((running && opcode_fetch_i && addr_unmapped_i) |=> r.cause[rss_pkg::C_BF])
		else $error("bad fetch flag missing");
	a_gpio_mode: assert property (!r.opt2 |-> !reset_pin_oe_o)
		else $error("pin driven without reset function");
	a_short_wake: assert property (($rose(r.st == rss_pkg::ST_WAKE) && r.opt1[rss_pkg::OPT1_SHORT] && src == 6'h00) |-> ##31 r.st == rss_pkg::ST_WAKE ##1 r.st == rss_pkg::ST_RUN)
		else $error("short wake delay wrong");

	// no reset entry of any kind this cycle; keeps the checks below from racing a reset
	assign quiet = (src == 6'h00) && !ext_low;
	assign svc_wr = wr_i && (addr_i == rss_pkg::A_WDSVC);

	// free running count in normal operation
	a_presc_free: assert property ((running && quiet && !svc_wr && !stop_exec_i)
		|=> r.presc == 12'($past(r.presc) + 12'h001))
		else $error("prescaler did not advance");

	// service write clears the watchdog and the upper prescaler stages
	a_svc_clear: assert property ((running && svc_wr && quiet)
		|=> r.wd == 6'h00 && r.presc[11:rss_pkg::SVC_LO] == 8'h00)
		else $error("watchdog service did not clear");

	// each wrap of the 12 stages advances the watchdog by one
	a_wd_tick: assert property ((wd_en && presc_tick && quiet && !svc_wr)
		|=> r.wd == 6'($past(r.wd) + 6'h01))
		else $error("watchdog did not tick on prescaler wrap");

	// break in monitor mode with the disable bit set freezes the watchdog
	a_wd_paused: assert property ((running && break_active_i && monitor_mode_i && r.brk && quiet
		&& !svc_wr) |=> r.wd == $past(r.wd))
		else $error("watchdog moved during break");

	// a stop clears the count ready for timing the wake delay
	a_stop_clears: assert property ((running && stop_exec_i && r.opt1[rss_pkg::OPT1_STOPEN] && quiet)
		|=> r.st == rss_pkg::ST_STOP && r.presc == 12'h000)
		else $error("stop did not clear the prescaler");

	// a brownout still present keeps the long phase at its start
	a_bo_hold: assert property ((r.st == rss_pkg::ST_LONG && long_src)
		|=> r.st == rss_pkg::ST_LONG && r.presc == 12'h000 && chip_reset_o)
		else $error("long phase ran while source active");

	// reset function enabled: pin pulled low through long and pin phases
	a_pin_drive: assert property (((r.st == rss_pkg::ST_LONG || r.st == rss_pkg::ST_PIN) && r.opt2)
		|-> reset_pin_oe_o)
		else $error("pin not driven during reset");

	// low pin while running halts the chip at once
	a_ext_entry: assert property ((ext_low && running && src == 6'h00)
		|=> r.st == rss_pkg::ST_EXT && chip_reset_o)
		else $error("pin low did not halt the chip");

	// a long enough low pulse leaves only the pin flag
	a_cause_pin: assert property ((r.st == rss_pkg::ST_EXT && r.low_cnt == rss_pkg::PIN_MIN_CNT
		&& r.pin_q && src == 6'h00) |=> r.cause[rss_pkg::C_PIN] && $onehot(r.cause))
		else $error("pin flag not set alone");

	// a data read from an unmapped address is harmless
	a_data_read_ok: assert property ((running && addr_unmapped_i && !opcode_fetch_i && !bad_opcode_i
		&& !stop_exec_i && !wd_ovf && !long_src && !ext_low) |=> !chip_reset_o)
		else $error("data read from unmapped address reset the chip");

endmodule

// ---- test/rss_pin_partner.sv ----
module rss_pin_partner (
	// design side of the pin
	input wire logic reset_pin_o,
	input wire logic reset_pin_oe_o,
	// external chip side
	input wire logic ext_low_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up holds the line high unless someone sinks it
	assign pin_o = ((reset_pin_oe_o && !reset_pin_o) || ext_low_i) ? 1'b0 : 1'b1;
endmodule

// ---- test/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
	logic pwr = 1'b0, bo = 1'b0, bop = 1'b0, stp = 1'b0, fetch = 1'b0, unm = 1'b0;
	logic wake = 1'b0, ext_low = 1'b0, brk = 1'b0, mon = 1'b0;
	logic pin, pin_drv, pin_oe, gpio, crst, osc, clks, bclk;
	int err_total = 0, n_tests = 0, rl, pl, n;
	// ********************
	// clock, device, far side
	// ********************
	always #2 clk = ~clk;
	rss_sequencer i_rss_sequencer (.clock_i(clk), .sys_rst_i(rst), .addr_i(addr), .wr_data_i(wdat),
		.wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .power_up_reset_req_i(pwr), .brownout_detect_i(bo),
		.bad_opcode_i(bop), .stop_exec_i(stp), .opcode_fetch_i(fetch), .addr_unmapped_i(unm),
		.break_active_i(brk), .monitor_mode_i(mon), .wake_i(wake), .reset_pin_i(pin),
		.reset_pin_o(pin_drv), .reset_pin_oe_o(pin_oe), .pin_gpio_o(gpio), .chip_reset_o(crst),
		.osc_en_o(osc), .internal_bus_clocks_o(clks), .bus_clk_en_o(bclk));
	rss_pin_partner i_rss_pin_partner (.reset_pin_o(pin_drv), .reset_pin_oe_o(pin_oe),
		.ext_low_i(ext_low), .pin_o(pin));
	// ********************
	// compare and bus tasks
	// ********************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk8(rdat, exp);
	endtask
	// waits a bounded time for chip reset, then counts its length and pin drive
	task automatic measure();
		rl = 0;
		pl = 0;
		for (int i = 0; i < 40 && crst !== 1'b1; i++)
			@(negedge clk);
		while (crst === 1'b1 && rl < 20000) begin
			if (pin_oe === 1'b1)
				pl++;
			rl++;
			@(negedge clk);
		end
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_power_up();
		@(posedge clk);
		measure();
		chk_n(rl, 4163);
		chk_n(pl, 0);
		chk8({7'h00, gpio}, 8'h01);
		rd_chk(rss_pkg::A_CAUSE, 8'h01);
		$display("done power up");
	endtask
	task automatic t_regs();
		logic [7:0] ad [5] = '{rss_pkg::A_OPT1, rss_pkg::A_OPT2, rss_pkg::A_BRK, rss_pkg::A_WDSVC, 8'h20};
		logic [7:0] ex [5] = '{8'h03, 8'h01, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			wr_reg(ad[i], 8'hFF);
			rd_chk(ad[i], ex[i]);
		end
		wr_reg(rss_pkg::A_CAUSE, 8'h00);
		rd_chk(rss_pkg::A_CAUSE, 8'h00);
		wr_reg(rss_pkg::A_OPT1, 8'h00);
		wr_reg(rss_pkg::A_BRK, 8'h00);
		$display("done registers");
	endtask
	// internal sources: bad opcode, stop while disabled, bad fetch
	task automatic t_internal(input int kind, input logic [7:0] cause);
		@(posedge clk);
		bop <= (kind == 0);
		stp <= (kind == 1);
		fetch <= (kind == 2);
		unm <= 1'b1;
		@(posedge clk);
		{bop, stp, fetch, unm} <= 4'h0;
		measure();
		chk_n(rl, (kind == 3) ? 0 : 67);
		chk_n(pl, (kind == 3) ? 0 : 32);
		rd_chk(rss_pkg::A_CAUSE, cause);
		rd_chk(rss_pkg::A_OPT2, 8'h01);
		$display("done internal %0d", kind);
	endtask
	// outside party sinks the pin; short pulses leave the flag alone
	task automatic t_pin(input int len, input logic [7:0] cause);
		wr_reg(rss_pkg::A_CAUSE, 8'h00);
		fork
			begin
				@(posedge clk);
				ext_low <= 1'b1;
				repeat (len) @(posedge clk);
				ext_low <= 1'b0;
			end
			measure();
		join
		chk_n(pl, 0);
		rd_chk(rss_pkg::A_CAUSE, cause);
		$display("done pin %0d", len);
	endtask
	task automatic t_brownout();
		fork
			begin
				@(posedge clk);
				bo <= 1'b1;
				repeat (20) @(posedge clk);
				bo <= 1'b0;
			end
			measure();
		join
		chk_n(rl >= 4163, 1);
		chk_n(pl >= 4128, 1);
		rd_chk(rss_pkg::A_CAUSE, 8'h20);
		$display("done brownout");
	endtask
	task automatic t_stop_wake();
		wr_reg(rss_pkg::A_OPT1, 8'h03);
		@(posedge clk);
		stp <= 1'b1;
		@(posedge clk);
		stp <= 1'b0;
		@(negedge clk);
		chk8({6'h00, osc, clks}, 8'h00);
		@(posedge clk);
		wake <= 1'b1;
		// wake taken at the next edge, then the short delay runs before clocks return
		n = 0;
		while (n < 5000) begin
			@(negedge clk);
			if (clks === 1'b1)
				break;
			n++;
		end
		chk_n(n, 1 + rss_pkg::WAKE_SHORT_CYC);
		chk8({6'h00, osc, clks}, 8'h03);
		@(posedge clk);
		wake <= 1'b0;
		n = 0;
		repeat (40) begin
			@(negedge clk);
			n += (bclk === 1'b1);
		end
		chk_n(n, 10);
		$display("done stop wake");
	endtask
	// break in monitor mode with the disable bit set parks the watchdog, then it runs on
	task automatic t_wdog_pause();
		wr_reg(rss_pkg::A_BRK, 8'h01);
		@(posedge clk);
		{brk, mon} <= 2'h3;
		repeat (4200) @(posedge clk);
		{brk, mon} <= 2'h0;
		repeat (4200) @(posedge clk);
		wr_reg(rss_pkg::A_WDSVC, 8'h5A);
		@(negedge clk);
		chk8({7'h00, crst}, 8'h00);
		rd_chk(rss_pkg::A_CAUSE, 8'h20);
		$display("done watchdog pause");
	endtask
	// ********************
	// main sequence and watchdog
	// ********************
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_power_up();
		t_regs();
		t_internal(0, 8'h08);
		t_internal(1, 8'h08);
		t_internal(3, 8'h08);
		t_internal(2, 8'h10);
		t_pin(10, 8'h00);
		t_pin(40, 8'h02);
		t_brownout();
		t_stop_wake();
		t_wdog_pause();
		tally_and_finish();
	end
	// whole run is near 17300 cycles; this limit leaves ample room
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
endmodule
